// file: design/bst_regs.vh
`ifndef BST_REGS_VH
`define BST_REGS_VH
// instruction register
`define BST_INS_WIDTH 3
`define BST_INS_CAPTURE 3'h1
`define BST_INS_RESET 3'h7
// instruction codes
`define BST_OP_EXTEST 3'h0
`define BST_OP_SAMPLE 3'h1
`define BST_OP_BYPASS 3'h7
// controller states
`define BST_ST_RESET 4'h0
`define BST_ST_IDLE 4'h1
`define BST_ST_SEL_DR 4'h2
`define BST_ST_CAP_DR 4'h3
`define BST_ST_SH_DR 4'h4
`define BST_ST_EX1_DR 4'h5
`define BST_ST_PAU_DR 4'h6
`define BST_ST_EX2_DR 4'h7
`define BST_ST_UPD_DR 4'h8
`define BST_ST_SEL_INS 4'h9
`define BST_ST_CAP_INS 4'hA
`define BST_ST_SH_INS 4'hB
`define BST_ST_EX1_INS 4'hC
`define BST_ST_PAU_INS 4'hD
`define BST_ST_EX2_INS 4'hE
`define BST_ST_UPD_INS 4'hF
// tester reset stretch: 100 ns recovery at 5 ns clock
`define BST_TRST_REC_NS 100
`define BST_CLK_NS 5
`define BST_TRST_REC_CYC ((`BST_TRST_REC_NS + `BST_CLK_NS - 1) / `BST_CLK_NS)
`endif

// file: design/bst_tap.v
`timescale 1ns/1ps
`include "bst_regs.vh"
module bst_tap #(
    parameter NUM_IO = 8
) (
    // system
    input wire clk_sys_in,
    input wire rst_in,
    // test port pins
    input wire tck_in,
    input wire tms_in,
    input wire tdi_in,
    input wire trst_n_in,
    output reg tdo_out,
    output reg tdo_oe_out,
    // core side signals
    input wire [NUM_IO-1:0] core_out_in,
    input wire [NUM_IO-1:0] core_oe_in,
    input wire [NUM_IO-1:0] pin_val_in,
    // pad side signals
    output reg [NUM_IO-1:0] pad_out_out,
    output reg [NUM_IO-1:0] pad_oe_out,
    output reg [NUM_IO-1:0] core_in_out,
    // status
    output reg [2:0] instr_out,
    output reg extest_out
);
    localparam BSR_LEN = 3 * NUM_IO;

    // two-stage synchronisers
    reg tck_s1_q, tck_s2_q, tck_s3_q;
    reg tms_s1_q, tms_s2_q;
    reg tdi_s1_q, tdi_s2_q;
    reg trst_s1_q, trst_s2_q;
    reg [NUM_IO-1:0] pin_s1_q, pin_s2_q;
    reg [NUM_IO-1:0] cout_s1_q, cout_s2_q;
    reg [NUM_IO-1:0] coe_s1_q, coe_s2_q;

    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            // test clock idles high; avoids a false rise after reset
            tck_s1_q <= 1'b1;
            tck_s2_q <= 1'b1;
            tck_s3_q <= 1'b1;
            tms_s1_q <= 1'b1;
            tms_s2_q <= 1'b1;
            tdi_s1_q <= 1'b1;
            tdi_s2_q <= 1'b1;
            trst_s1_q <= 1'b0;
            trst_s2_q <= 1'b0;
        end else begin
            tck_s1_q <= tck_in;
            tck_s2_q <= tck_s1_q;
            tck_s3_q <= tck_s2_q;
            tms_s1_q <= tms_in;
            tms_s2_q <= tms_s1_q;
            tdi_s1_q <= tdi_in;
            tdi_s2_q <= tdi_s1_q;
            trst_s1_q <= ~trst_n_in;
            trst_s2_q <= trst_s1_q;
        end
    end

    always @(posedge clk_sys_in) begin
        pin_s1_q <= pin_val_in;
        pin_s2_q <= pin_s1_q;
        cout_s1_q <= core_out_in;
        cout_s2_q <= cout_s1_q;
        coe_s1_q <= core_oe_in;
        coe_s2_q <= coe_s1_q;
    end

    wire tck_rise = tck_s2_q & ~tck_s3_q;
    wire tck_fall = ~tck_s2_q & tck_s3_q;
    wire trst_act = trst_s2_q;

    // controller
    wire [3:0] st;
    bst_tap_fsm u_fsm (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .tck_rise_in(tck_rise),
        .tms_in(tms_s2_q),
        .trst_in(trst_act),
        .state_out(st)
    );

    // instruction path
    reg [`BST_INS_WIDTH-1:0] instr_shift_q;
    reg [`BST_INS_WIDTH-1:0] instr_q;
    reg bypass_q;
    reg [BSR_LEN-1:0] bsr_shift_q;
    reg [BSR_LEN-1:0] bsr_upd_q;
    reg tdo_d;
    reg tdo_en_d;

    wire sel_bsr = (instr_q == `BST_OP_EXTEST) || (instr_q == `BST_OP_SAMPLE);
    wire sel_byp = ~sel_bsr;
    wire is_extest = (instr_q == `BST_OP_EXTEST);

    always @(posedge clk_sys_in) begin
        if (rst_in || trst_act || st == `BST_ST_RESET) begin
            instr_shift_q <= `BST_INS_RESET;
            instr_q <= `BST_INS_RESET;
        end else if (tck_rise) begin
            case (st)
                `BST_ST_CAP_INS: instr_shift_q <= `BST_INS_CAPTURE;
                `BST_ST_SH_INS: begin
                    instr_shift_q <= {tdi_s2_q, instr_shift_q[`BST_INS_WIDTH-1:1]};
                end
                `BST_ST_UPD_INS: instr_q <= instr_shift_q;
                default: instr_shift_q <= instr_shift_q;
            endcase
        end
    end

    // bypass and boundary-scan data path
    wire [BSR_LEN-1:0] bsr_cap = {coe_s2_q, cout_s2_q, pin_s2_q};

    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            bypass_q <= 1'b0;
            bsr_shift_q <= {BSR_LEN{1'b0}};
            bsr_upd_q <= {BSR_LEN{1'b0}};
        end else if (tck_rise) begin
            case (st)
                `BST_ST_CAP_DR: begin
                    bypass_q <= 1'b0;
                    if (sel_bsr) begin
                        bsr_shift_q <= bsr_cap;
                    end
                end
                `BST_ST_SH_DR: begin
                    if (sel_byp) begin
                        bypass_q <= tdi_s2_q;
                    end else begin
                        bsr_shift_q <= {tdi_s2_q, bsr_shift_q[BSR_LEN-1:1]};
                    end
                end
                `BST_ST_UPD_DR: begin
                    if (sel_bsr) begin
                        bsr_upd_q <= bsr_shift_q;
                    end
                end
                default: bypass_q <= bypass_q;
            endcase
        end
    end

    // serial output, updated on falling test clock
    always @* begin
        tdo_en_d = 1'b0;
        tdo_d = 1'b0;
        if (st == `BST_ST_SH_INS) begin
            tdo_en_d = 1'b1;
            tdo_d = instr_shift_q[0];
        end else if (st == `BST_ST_SH_DR) begin
            tdo_en_d = 1'b1;
            tdo_d = sel_byp ? bypass_q : bsr_shift_q[0];
        end
    end

    always @(posedge clk_sys_in) begin
        if (rst_in || trst_act) begin
            tdo_out <= 1'b0;
            tdo_oe_out <= 1'b0;
        end else if (tck_fall) begin
            tdo_out <= tdo_d;
            tdo_oe_out <= tdo_en_d;
        end
    end

    // pad muxing: extest drives pads from update stage
    genvar i;
    generate
        for (i = 0; i < NUM_IO; i = i + 1) begin : g_cell
            always @(posedge clk_sys_in) begin
                if (rst_in) begin
                    pad_out_out[i] <= 1'b0;
                    pad_oe_out[i] <= 1'b0;
                    core_in_out[i] <= 1'b0;
                end else begin
                    pad_out_out[i] <= is_extest ? bsr_upd_q[NUM_IO+i] : cout_s2_q[i];
                    pad_oe_out[i] <= is_extest ? bsr_upd_q[2*NUM_IO+i] : coe_s2_q[i];
                    core_in_out[i] <= pin_s2_q[i];
                end
            end
        end
    endgenerate

    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            instr_out <= `BST_INS_RESET;
            extest_out <= 1'b0;
        end else begin
            instr_out <= instr_q;
            extest_out <= is_extest;
        end
    end
endmodule // bst_tap

// file: design/bst_tap_fsm.v
`timescale 1ns/1ps
`include "bst_regs.vh"
module bst_tap_fsm (
    // clock and reset
    input wire clk_sys_in,
    input wire rst_in,
    // test clock events
    input wire tck_rise_in,
    input wire tms_in,
    input wire trst_in,
    // state
    output reg [3:0] state_out
);
    reg [3:0] state_d;

    always @* begin
        state_d = state_out;
        case (state_out)
            `BST_ST_RESET: state_d = tms_in ? `BST_ST_RESET : `BST_ST_IDLE;
            `BST_ST_IDLE: state_d = tms_in ? `BST_ST_SEL_DR : `BST_ST_IDLE;
            `BST_ST_SEL_DR: state_d = tms_in ? `BST_ST_SEL_INS : `BST_ST_CAP_DR;
            `BST_ST_CAP_DR: state_d = tms_in ? `BST_ST_EX1_DR : `BST_ST_SH_DR;
            `BST_ST_SH_DR: state_d = tms_in ? `BST_ST_EX1_DR : `BST_ST_SH_DR;
            `BST_ST_EX1_DR: state_d = tms_in ? `BST_ST_UPD_DR : `BST_ST_PAU_DR;
            `BST_ST_PAU_DR: state_d = tms_in ? `BST_ST_EX2_DR : `BST_ST_PAU_DR;
            `BST_ST_EX2_DR: state_d = tms_in ? `BST_ST_UPD_DR : `BST_ST_SH_DR;
            `BST_ST_UPD_DR: state_d = tms_in ? `BST_ST_SEL_DR : `BST_ST_IDLE;
            `BST_ST_SEL_INS: state_d = tms_in ? `BST_ST_RESET : `BST_ST_CAP_INS;
            `BST_ST_CAP_INS: state_d = tms_in ? `BST_ST_EX1_INS : `BST_ST_SH_INS;
            `BST_ST_SH_INS: state_d = tms_in ? `BST_ST_EX1_INS : `BST_ST_SH_INS;
            `BST_ST_EX1_INS: state_d = tms_in ? `BST_ST_UPD_INS : `BST_ST_PAU_INS;
            `BST_ST_PAU_INS: state_d = tms_in ? `BST_ST_EX2_INS : `BST_ST_PAU_INS;
            `BST_ST_EX2_INS: state_d = tms_in ? `BST_ST_UPD_INS : `BST_ST_SH_INS;
            `BST_ST_UPD_INS: state_d = tms_in ? `BST_ST_SEL_DR : `BST_ST_IDLE;
            default: state_d = `BST_ST_RESET;
        endcase
    end

    always @(posedge clk_sys_in) begin
        if (rst_in || trst_in) begin
            state_out <= `BST_ST_RESET;
        end else if (tck_rise_in) begin
            state_out <= state_d;
        end
    end
endmodule // bst_tap_fsm

// file: testbench/bst_tap_bench.sv
`timescale 1ns/1ps
`include "bst_regs.vh"
module bst_tap_bench;
    logic clk_sys_in, rst_in, tck, tms, tdi, trst_n, tdo, tdo_oe, extest, q;
    logic [7:0] core_out, core_oe, pin_val, pad_out, pad_oe, core_in;
    logic [2:0] instr;
    logic [23:0] got;
    int failures, n_compared;
    bst_tap #(.NUM_IO(8)) dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .tck_in(tck),
        .tms_in(tms), .tdi_in(tdi), .trst_n_in(trst_n), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
        .core_out_in(core_out), .core_oe_in(core_oe), .pin_val_in(pin_val),
        .pad_out_out(pad_out), .pad_oe_out(pad_oe), .core_in_out(core_in),
        .instr_out(instr), .extest_out(extest));
    bst_tester tester_u (.clk_sys_in(clk_sys_in), .tdo_in(tdo), .tck_out(tck), .tms_out(tms),
        .tdi_out(tdi), .trst_n_out(trst_n));
    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // from idle: instruction or data scan of n bits, back to idle
    task automatic scan(input logic is_instr, input int n, input logic [23:0] d);
        tester_u.step(1'b1, 1'b0, q);
        if (is_instr) tester_u.step(1'b1, 1'b0, q);
        tester_u.step(1'b0, 1'b0, q);
        tester_u.step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            tester_u.step(i == n - 1, d[i], q);
            got[i] = q;
        end
        tester_u.step(1'b1, 1'b0, q);
        tester_u.step(1'b0, 1'b0, q);
    endtask
    task automatic load(input logic [2:0] c);
        scan(1'b1, 3, {21'h0, c});
        chk(got[2:0], `BST_INS_CAPTURE);
        chk(instr, c);
        chk(extest, c == `BST_OP_EXTEST);
    endtask
    task automatic test_codes();
        chk(instr, `BST_INS_RESET);
        tester_u.step(1'b0, 1'b0, q);
        load(`BST_OP_EXTEST);
        load(`BST_OP_SAMPLE);
        load(`BST_OP_BYPASS);
        scan(1'b1, 4, 24'hE);
        chk(got[3:0], 4'h1);
        chk(instr, `BST_OP_BYPASS);
        $display("codes done");
    endtask
    task automatic test_paths();
        scan(1'b0, 8, 24'hB5);
        chk(got[7:0], 8'h6A);
        chk(pad_out, core_out);
        chk(core_in, pin_val);
        load(`BST_OP_SAMPLE);
        scan(1'b0, 24, 24'hC35A00);
        chk(got, {core_oe, core_out, pin_val});
        load(`BST_OP_EXTEST);
        chk(pad_out, 8'h5A);
        chk(pad_oe, 8'hC3);
        $display("paths done");
    endtask
    task automatic test_resets();
        for (int i = 0; i < 5; i++) tester_u.step(1'b1, 1'b0, q);
        chk(instr, `BST_OP_BYPASS);
        tester_u.step(1'b0, 1'b0, q);
        load(`BST_OP_EXTEST);
        tester_u.step(1'b1, 1'b0, q);
        tester_u.step(1'b0, 1'b0, q);
        tester_u.step(1'b0, 1'b0, q);
        // enable follows the first falling edge inside the shift state
        tester_u.step(1'b0, 1'b0, q);
        chk(tdo_oe, 1'b1);
        tester_u.set_reset(1'b0);
        repeat (8) @(posedge clk_sys_in);
        chk(tdo_oe, 1'b0);
        chk(instr, `BST_OP_BYPASS);
        tester_u.set_reset(1'b1);
        repeat (21) @(posedge clk_sys_in);
        $display("resets done");
    endtask
    task automatic complete_run();
        $display("compared=%0d failures=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys_in);
        failures++;
        complete_run();
    end
    initial begin
        rst_in = 1'b1;
        core_out = 8'h3C;
        core_oe = 8'hF0;
        pin_val = 8'hA5;
        repeat (20) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        repeat (21) @(posedge clk_sys_in);
        test_codes();
        test_paths();
        test_resets();
        complete_run();
    end
endmodule // bst_tap_bench

// file: testbench/bst_tap_monitor.sv
`timescale 1ns/1ps
`include "bst_regs.vh"
module bst_tap_monitor #(
    parameter NUM_IO = 8
) (
    // system and test port
    input wire clk_sys_in,
    input wire rst_in,
    input wire tck_in,
    input wire tms_in,
    input wire tdi_in,
    input wire trst_n_in,
    input wire tdo_out,
    input wire tdo_oe_out,
    // core and pad side
    input wire [NUM_IO-1:0] core_out_in,
    input wire [NUM_IO-1:0] core_oe_in,
    input wire [NUM_IO-1:0] pin_val_in,
    input wire [NUM_IO-1:0] pad_out_out,
    input wire [NUM_IO-1:0] pad_oe_out,
    input wire [NUM_IO-1:0] core_in_out,
    input wire [2:0] instr_out,
    input wire extest_out
);
    reg [4:0] trst_hist_q;
    wire quiet = trst_n_in && (&trst_hist_q);
    always @(posedge clk_sys_in) begin
        trst_hist_q <= {trst_hist_q[3:0], trst_n_in};
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    sequence trst_held;
        !trst_n_in [*5];
    endsequence
    sequence core_steady;
        (!extest_out && $stable(core_out_in)) [*6];
    endsequence
    AST_TDO_FALL: assert property ($changed(tdo_out) && quiet |-> !$past(tck_in) && !$past(tck_in, 2))
        else $error("tdo changed outside a low test clock phase");
    AST_OE_FALL: assert property ($changed(tdo_oe_out) && quiet |-> !$past(tck_in))
        else $error("tdo enable changed outside a low test clock phase");
    AST_TRST_OFF: assert property ($fell(trst_n_in) |-> ##[1:5] !tdo_oe_out)
        else $error("tdo still enabled after test reset");
    AST_TRST_BYP: assert property (trst_held |-> instr_out == `BST_OP_BYPASS)
        else $error("test reset did not select bypass");
    AST_EXT_CODE: assert property ($rose(extest_out) |-> instr_out == `BST_OP_EXTEST)
        else $error("extest raised for another code");
    AST_CODES: assert property (instr_out inside {3'h0, 3'h1, 3'h7})
        else $error("undecoded instruction active");
    AST_PAD_PASS: assert property (core_steady |-> pad_out_out == core_out_in)
        else $error("pad output does not follow core");
    AST_PIN_OBS: assert property ($stable(pin_val_in) [*6] |-> core_in_out == pin_val_in)
        else $error("core input does not follow pin");
endmodule // bst_tap_monitor
bind bst_tap bst_tap_monitor #(.NUM_IO(NUM_IO)) mon_u (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .tck_in(tck_in),
    .tms_in(tms_in),
    .tdi_in(tdi_in),
    .trst_n_in(trst_n_in),
    .tdo_out(tdo_out),
    .tdo_oe_out(tdo_oe_out),
    .core_out_in(core_out_in),
    .core_oe_in(core_oe_in),
    .pin_val_in(pin_val_in),
    .pad_out_out(pad_out_out),
    .pad_oe_out(pad_oe_out),
    .core_in_out(core_in_out),
    .instr_out(instr_out),
    .extest_out(extest_out)
);

// file: testbench/bst_tester.sv
`timescale 1ns/1ps
module bst_tester (
    // clock and test port
    input wire clk_sys_in,
    input wire tdo_in,
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    output logic trst_n_out
);
    initial begin
        tck_out = 1'b1;
        tms_out = 1'b1;
        tdi_out = 1'b0;
        trst_n_out = 1'b1;
    end
    // one 48 ns test clock, off the system edge; clock rests high between calls
    task automatic step(input logic m, input logic d, output logic q);
        #1;
        tck_out = 1'b0;
        tms_out = m;
        tdi_out = d;
        #24;
        q = tdo_in;
        tck_out = 1'b1;
        #15;
        tdi_out = ~d;
        #8;
    endtask
    task automatic set_reset(input logic v);
        @(posedge clk_sys_in);
        trst_n_out <= v;
    endtask
endmodule // bst_tester
